// File: include/cfs_cfg.svh
// Address map, field positions and reset values of the FIFO status block.
// Assumes an APB slave with 12-bit byte addresses and 32-bit data.
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define CFS_OFS_MODE 12'h000
`define CFS_OFS_BASE 12'h004
`define CFS_FIFO_WIN_LO 12'h100
`define CFS_FIFO_WIN_HI 12'h2ff
`define CFS_SUB_CTRL 2'h0
`define CFS_SUB_INT 2'h1
`define CFS_SUB_UA 2'h2
`define CFS_SUB_CI 2'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CFS_MODE_LSB 21
`define CFS_MODE_CONFIG 3'h4
`define CFS_MODE_RST 3'h4
`define CFS_CTRL_DIR_BIT 7
`define CFS_CTRL_ADV_BIT 13
`define CFS_CTRL_FRST_BIT 14
`define CFS_CTRL_DEPTH_LSB 16
`define CFS_INT_TXIE_LSB 24
`define CFS_INT_RXIE_LSB 16
`define CFS_INT_TXIF_LSB 8
`define CFS_INT_RXIF_LSB 0
`define CFS_IE_RST 7'h00
`define CFS_DEPTH_RST 5'h00

`endif

// File: include/cfs_pkg.sv
// Types shared by the FIFO status block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cfs_pkg;

  // Event kinds raised by the protocol engine (one-hot)
  typedef enum logic [1:0] {
    CFS_EV_RX_STORE = 2'b01,
    CFS_EV_TX_DONE  = 2'b10
  } cfs_ev_kind_t;

  typedef struct packed {
    logic valid;
    cfs_ev_kind_t kind;
    logic [4:0] fifo;
  } cfs_eng_ev_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cfs_apb_req_t;

endpackage
`default_nettype wire

// File: design/cfs_fifo_status.sv
// Status, interrupt-enable and pointer read-back for 32 message FIFOs.
// Assumes an APB master on clk_sys and a protocol engine on the same clock.
// Function
// - Tx not-full flag tracks room; rx reads 0
// - Tx half flag when occupancy at most half
// - Tx empty flag when nothing queued
// - Rx overflow flag set on overflow, writable
// - Rx full flag when all slots used
// - Rx half flag when occupancy at least half
// - Rx not-empty flag when message held
// - Occupancy flags are live and read-only
// - Seven enable bits, reset zero, R/W
// - Unused interrupt register bits read zero
// - Tx user address gives FIFO head
// - Rx user address gives FIFO tail
// - User address low two bits zero
// - Tx index names next slot to send
// - Rx index names next slot to fill
// - Registers replicated for 32 FIFOs
// - Direction bit selects transmit or receive
// - Advance bit moves head or tail one
// - Depth field encodes depth minus one
// - Config mode is mode field 100
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"

module cfs_fifo_status
  import cfs_pkg::*;
#(
  parameter int NUM_FIFO = 32,
  parameter int MSG_BYTES = 16
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire cfs_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Protocol engine side
  input wire cfs_eng_ev_t eng_ev,
  output logic [NUM_FIFO-1:0] tx_pending,
  output logic [NUM_FIFO-1:0] rx_room,
  // Per-FIFO interrupt requests
  output logic [NUM_FIFO-1:0] fifo_irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic setup_cyc;
  logic wr_acc;
  logic in_fifo_win;
  logic [4:0] acc_fifo;
  logic [1:0] acc_sub;
  logic acc_aligned;
  logic cfg_mode;
  logic [2:0] operating_mode_field_r;
  logic [31:0] base_addr_r;

  assign setup_cyc = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign in_fifo_win = (apb_req.paddr >= `CFS_FIFO_WIN_LO) &&
                       (apb_req.paddr <= `CFS_FIFO_WIN_HI);
  // Window opens at 0x100, so bit 8 is inverted to count from zero
  assign acc_fifo = {~apb_req.paddr[8], apb_req.paddr[7:4]};
  assign acc_sub = apb_req.paddr[3:2];
  assign acc_aligned = (apb_req.paddr[1:0] == 2'b00);
  assign cfg_mode = (operating_mode_field_r == `CFS_MODE_CONFIG);
  assign pready = apb_req.psel & apb_req.penable;

  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      operating_mode_field_r <= `CFS_MODE_RST;
    end
    else if (wr_acc && apb_req.paddr == `CFS_OFS_MODE)
    begin
      operating_mode_field_r <= apb_req.pwdata[`CFS_MODE_LSB +: 3];
    end
  end

  // Base moves only in config mode, or live addresses would jump
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      base_addr_r <= 32'h0000_0000;
    end
    else if (wr_acc && apb_req.paddr == `CFS_OFS_BASE && cfg_mode)
    begin
      base_addr_r <= {apb_req.pwdata[31:2], 2'b00};
    end
  end

  // ---------------------------------------------------------------
  // Per-FIFO state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_word [NUM_FIFO];
  logic [31:0] int_word [NUM_FIFO];
  logic [31:0] ua_word [NUM_FIFO];
  logic [31:0] ci_word [NUM_FIFO];
  logic [10:0] slot_start [NUM_FIFO+1];

  assign slot_start[0] = 11'h000;

  genvar g;
  generate
    for (g = 0; g < NUM_FIFO; g++)
    begin : g_fifo
      logic fifo_direction_sel_r;
      logic [4:0] depth_field_r;
      logic [6:0] irq_en_r;
      logic rx_overrun_r;
      logic [5:0] count_r;
      logic [5:0] count_nxt;
      logic [4:0] sw_idx_r;
      logic [4:0] ci_r;
      logic [5:0] depth;
      logic acc_hit;
      logic ctrl_wr;
      logic int_wr;
      logic pointer_advance;
      logic adv_ok;
      logic ev_hit;
      logic store_ok;
      logic store_lost;
      logic sent_ok;
      logic fifo_rst;
      logic full;
      logic empty;
      logic [3:0] rx_flags;
      logic [2:0] tx_flags;
      logic [10:0] slot;
      logic [31:0] slot_bytes;
      logic tx_half;
      logic rx_half;

      // Unaligned writes are refused just like unaligned reads
      assign acc_hit = wr_acc && in_fifo_win && acc_aligned &&
                       acc_fifo == 5'(g);
      assign ctrl_wr = acc_hit && acc_sub == `CFS_SUB_CTRL;
      assign int_wr = acc_hit && acc_sub == `CFS_SUB_INT;
      assign pointer_advance = ctrl_wr &
                               apb_req.pwdata[`CFS_CTRL_ADV_BIT];
      assign fifo_rst = ctrl_wr & apb_req.pwdata[`CFS_CTRL_FRST_BIT];
      assign depth = {1'b0, depth_field_r} + 6'h01;
      assign full = (count_r == depth);
      assign empty = (count_r == 6'h00);

      // Advance past the limit is dropped rather than corrupting count
      assign adv_ok = pointer_advance &
                      (fifo_direction_sel_r ? ~full : ~empty);
      assign ev_hit = eng_ev.valid && eng_ev.fifo == 5'(g);
      assign store_ok = ev_hit && eng_ev.kind == CFS_EV_RX_STORE &&
                        !fifo_direction_sel_r && !full;
      assign store_lost = ev_hit && eng_ev.kind == CFS_EV_RX_STORE &&
                          !fifo_direction_sel_r && full;
      assign sent_ok = ev_hit && eng_ev.kind == CFS_EV_TX_DONE &&
                       fifo_direction_sel_r && !empty;

      // Software fills a tx FIFO, engine drains; rx the other way round
      always_comb
      begin
        count_nxt = count_r;
        if (fifo_direction_sel_r)
        begin
          count_nxt = count_r + {5'h00, adv_ok} - {5'h00, sent_ok};
        end
        else
        begin
          count_nxt = count_r + {5'h00, store_ok} - {5'h00, adv_ok};
        end
      end

      // Direction and depth only change in config mode
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          fifo_direction_sel_r <= 1'b0;
          depth_field_r <= `CFS_DEPTH_RST;
        end
        else if (ctrl_wr && cfg_mode)
        begin
          fifo_direction_sel_r <= apb_req.pwdata[`CFS_CTRL_DIR_BIT];
          depth_field_r <= apb_req.pwdata[`CFS_CTRL_DEPTH_LSB +: 5];
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          irq_en_r <= `CFS_IE_RST;
        end
        else if (int_wr)
        begin
          irq_en_r <= {apb_req.pwdata[`CFS_INT_TXIE_LSB +: 3],
                       apb_req.pwdata[`CFS_INT_RXIE_LSB +: 4]};
        end
      end

      // Overflow event beats a same-cycle software write
      always_ff @(posedge clk_sys)
      begin
        if (rst || fifo_rst)
        begin
          rx_overrun_r <= 1'b0;
        end
        else if (store_lost)
        begin
          rx_overrun_r <= 1'b1;
        end
        else if (int_wr)
        begin
          rx_overrun_r <= apb_req.pwdata[`CFS_INT_RXIF_LSB + 3];
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst || fifo_rst)
        begin
          count_r <= 6'h00;
        end
        else
        begin
          count_r <= count_nxt;
        end
      end

      // Indices wrap at the configured depth, like the ring itself
      always_ff @(posedge clk_sys)
      begin
        if (rst || fifo_rst)
        begin
          sw_idx_r <= 5'h00;
        end
        else if (adv_ok)
        begin
          sw_idx_r <= (sw_idx_r == depth_field_r) ? 5'h00 :
                      sw_idx_r + 5'h01;
        end
      end

      // Engine side moves only on accepted events
      always_ff @(posedge clk_sys)
      begin
        if (rst || fifo_rst)
        begin
          ci_r <= 5'h00;
        end
        else if (store_ok || sent_ok)
        begin
          ci_r <= (ci_r == depth_field_r) ? 5'h00 :
                  ci_r + 5'h01;
        end
      end

      // Live occupancy flags, masked to zero in the other direction
      // Twice the count is compared so odd depths split correctly
      assign tx_half = ({count_r, 1'b0} <= {1'b0, depth});
      assign rx_half = ({count_r, 1'b0} >= {1'b0, depth});

      always_comb
      begin
        tx_flags = 3'h0;
        rx_flags = 4'h0;
        if (fifo_direction_sel_r)
        begin
          tx_flags = {~full, tx_half, empty};
        end
        else
        begin
          rx_flags = {rx_overrun_r, full, rx_half,
                      ~empty};
        end
      end

      assign int_word[g] = {5'h00, irq_en_r[6:4], 4'h0, irq_en_r[3:0],
                            5'h00, tx_flags, 4'h0, rx_flags};
      assign ctrl_word[g] = {11'h000, depth_field_r, 8'h00,
                             fifo_direction_sel_r, 7'h00};
      assign ci_word[g] = {27'h0000000, ci_r};

      // Head in tx, tail in rx: both are the software-side index
      assign slot = slot_start[g] + {6'h00, sw_idx_r};
      assign slot_start[g+1] = slot_start[g] + {5'h00, depth};
      // Byte offset of the slot; its low two bits drop out below
      assign slot_bytes = 32'(slot) * 32'(MSG_BYTES);
      assign ua_word[g] = {base_addr_r[31:2] + slot_bytes[31:2],
                           2'b00};

      assign fifo_irq[g] = |({tx_flags, rx_flags} & irq_en_r);
      assign tx_pending[g] = fifo_direction_sel_r & ~empty;
      assign rx_room[g] = ~fifo_direction_sel_r & ~full;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ---------------------------------------------------------------
  // Sampling at setup keeps prdata a flop; value is one cycle old
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_cyc)
    begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_req.paddr == `CFS_OFS_MODE)
      begin
        prdata <= {8'h00, operating_mode_field_r, 21'h000000};
      end
      else if (apb_req.paddr == `CFS_OFS_BASE)
      begin
        prdata <= base_addr_r;
      end
      else if (in_fifo_win && acc_aligned)
      begin
        case (acc_sub)
          `CFS_SUB_CTRL: prdata <= ctrl_word[acc_fifo];
          `CFS_SUB_INT: prdata <= int_word[acc_fifo];
          `CFS_SUB_UA: prdata <= ua_word[acc_fifo];
          `CFS_SUB_CI: prdata <= ci_word[acc_fifo];
          default: prdata <= 32'h0000_0000;
        endcase
      end
      else
      begin
        pslverr <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: dv/cfs_fifo_status_assertions.sv
// Port-level checker for the FIFO status block.
// Assumes the top module's ports and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cfs_fifo_status_assertions
  import cfs_pkg::*;
#(
  parameter int NUM_FIFO = 32
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB
  input wire cfs_apb_req_t apb_req,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Engine and status
  input wire cfs_eng_ev_t eng_ev,
  input wire logic [NUM_FIFO-1:0] tx_pending,
  input wire logic [NUM_FIFO-1:0] rx_room,
  input wire logic [NUM_FIFO-1:0] fifo_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_bad;
    s_setup ##0 (apb_req.paddr[1:0] != 2'h0);
  endsequence
  // Write excluded: a same-cycle FIFO reset would free a slot
  sequence s_full_store;
    eng_ev.valid && eng_ev.kind == CFS_EV_RX_STORE
      && !rx_room[eng_ev.fifo]
      && !(apb_req.psel && apb_req.penable && apb_req.pwrite);
  endsequence

  a_ready_access: assert property (
    apb_req.psel && apb_req.penable |-> pready)
    else $error("pready missing in access");
  a_ready_idle: assert property (
    !apb_req.psel |-> !pready)
    else $error("pready without select");
  a_bad_addr: assert property (
    s_bad |=> pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  a_mode_ok: assert property (
    s_setup ##0 (apb_req.paddr == 12'h000) |=> !pslverr)
    else $error("mode register refused");
  a_read_hold: assert property (
    !(apb_req.psel && !apb_req.penable)
      |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved outside setup");
  a_dir_excl: assert property (
    (tx_pending & rx_room) == '0)
    else $error("FIFO both transmit and receive");
  a_rst_state: assert property (
    $fell(rst) |-> fifo_irq == '0 && tx_pending == '0
      && rx_room == '1)
    else $error("bad state after reset");
  a_full_stays: assert property (
    s_full_store |=> !rx_room[$past(eng_ev.fifo)])
    else $error("store into full FIFO freed room");
endmodule

bind cfs_fifo_status cfs_fifo_status_assertions #(.NUM_FIFO(NUM_FIFO))
  u_chk (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .eng_ev(eng_ev), .tx_pending(tx_pending), .rx_room(rx_room),
  .fifo_irq(fifo_irq));
`default_nettype wire

// File: dv/cfs_eng_model.sv
// Protocol engine model: one-cycle store and sent events.
// Assumes the caller returns from each call after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cfs_eng_model
  import cfs_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Event out
  output cfs_eng_ev_t eng_ev
);
  initial eng_ev = '0;
  // Gap gives a slow engine; idle target lines show a changed value
  task automatic send(input cfs_ev_kind_t k, input logic [4:0] f,
    input int gap);
    repeat (gap) @(posedge clk_sys);
    eng_ev <= '{1'b1, k, f};
    @(posedge clk_sys);
    eng_ev <= '{1'b0, k, ~f};
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: dv/cfs_fifo_status_tb_top.sv
// Bench for the FIFO status block: APB master, engine, checks.
// Assumes the design, package, checker and engine model.
`timescale 1ns/1ps
`default_nettype none
module cfs_fifo_status_tb_top;
  import cfs_pkg::*;
  localparam logic [31:0] BA = 32'h1000_0000;
  logic clk_sys, rst, pready, pslverr;
  logic [31:0] prdata, txp, rxr, irq;
  cfs_apb_req_t req;
  cfs_eng_ev_t ev;
  int n_errors, checks_done;
  logic [31:0] fl [4] = '{32'h1, 32'h3, 32'h3, 32'h7};

  cfs_fifo_status dut (.clk_sys(clk_sys), .rst(rst), .apb_req(req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .eng_ev(ev),
    .tx_pending(txp), .rx_room(rxr), .fifo_irq(irq));
  cfs_eng_model eng (.clk_sys(clk_sys), .eng_ev(ev));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] fa(input int n, input int s);
    return 12'(12'h100 + n * 16 + s * 4);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(12'h000, 32'h0080_0000);
    rd(fa(31, 1), 32'h0);
    rd(fa(31, 3), 32'h0);
    chk(rxr & ~txp & ~irq, 32'hffff_ffff);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h101, 32'h001f_0080, q, e);
    chk({31'h0, e}, 32'h1);
    rd(fa(0, 0), 32'h0);
    wr(12'h004, BA | 32'h3);
    rd(12'h004, BA);
    wr(fa(0, 0), 32'h0003_0000);
    wr(fa(1, 0), 32'h0001_0080);
    wr(12'h000, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_rx;
    wr(fa(0, 1), 32'h000f_0000);
    rd(fa(0, 2), BA);
    for (int i = 0; i < 4; i++)
    begin
      eng.send(CFS_EV_RX_STORE, 5'h0, i);
      rd(fa(0, 1), 32'h000f_0000 | fl[i]);
    end
    chk({irq[0], rxr[0]}, 32'h2);
    rd(fa(0, 3), 32'h0);
    eng.send(CFS_EV_RX_STORE, 5'h0, 0);
    rd(fa(0, 1), 32'h000f_000f);
    wr(fa(0, 1), 32'h0000_00f7);
    rd(fa(0, 1), 32'h7);
    chk({31'h0, irq[0]}, 32'h0);
    wr(fa(0, 0), 32'h2000);
    rd(fa(0, 2), BA + 32'h10);
    rd(fa(0, 1), 32'h3);
    wr(fa(0, 0), 32'h4000);
    rd(fa(0, 1), 32'h0);
    rd(fa(0, 2), BA);
    rd(fa(0, 3), 32'h0);
    $display("t_rx done");
  endtask

  task automatic t_tx;
    rd(fa(1, 0), 32'h0001_0080);
    wr(12'h004, 32'h0);
    rd(12'h004, BA);
    rd(fa(1, 1), 32'h700);
    rd(fa(1, 2), BA + 32'h40);
    wr(fa(1, 0), 32'h2000);
    rd(fa(1, 1), 32'h600);
    chk({31'h0, txp[1]}, 32'h1);
    wr(fa(1, 0), 32'h2000);
    rd(fa(1, 1), 32'h0);
    wr(fa(1, 0), 32'h2000);
    rd(fa(1, 2), BA + 32'h40);
    eng.send(CFS_EV_RX_STORE, 5'h1, 0);
    rd(fa(1, 1), 32'h0);
    eng.send(CFS_EV_TX_DONE, 5'h1, 3);
    rd(fa(1, 1), 32'h600);
    rd(fa(1, 3), 32'h1);
    eng.send(CFS_EV_TX_DONE, 5'h1, 0);
    rd(fa(1, 3), 32'h0);
    wr(fa(1, 1), 32'h0100_0000);
    rd(fa(1, 1), 32'h0100_0700);
    chk({irq[1], rxr[1]}, 32'h2);
    $display("t_tx done");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    req = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_rx();
    t_tx();
    report_and_stop();
  end

  // About 45 transfers of 3 cycles; far more than enough
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
